//--- hw/hoc_map.svh
// Register map, field positions, reset values and timing constants
// Assumes inclusion by hoc_pkg users and the main design file only
`ifndef HOC_MAP_SVH
`define HOC_MAP_SVH

`define HOC_ADR_CTRL 8'h00
`define HOC_ADR_PICKPU 8'h04
`define HOC_ADR_PICKREL 8'h08
`define HOC_ADR_DELAY 8'h0C
`define HOC_ADR_STATUS 8'h10
`define HOC_ADR_RATIO 8'h14
`define HOC_ADR_EXPECT 8'h18
`define HOC_ADR_REMAIN 8'h1C
`define HOC_ADR_GROUP 8'h20

// Control register fields
`define HOC_CTL_HARM_LO 0
`define HOC_CTL_MODE 5
`define HOC_CTL_SRC_LO 6
`define HOC_CTL_FORCE_LO 8
`define HOC_CTL_FEN 10
`define HOC_CTL_IDMT 11

`define HOC_CTRL_RST 32'h0000_0002
`define HOC_PICKPU_RST 16'h0014
`define HOC_PICKREL_RST 16'h07D0
`define HOC_DELAY_RST 16'h0014
`define HOC_RESET_RATIO 16'h0061
`define HOC_HARM_MIN 5'h02
`define HOC_HARM_MAX 5'h13
`define HOC_STEP_MS 5
`define HOC_CLK_KHZ 50000
`define HOC_STEP_CYC (`HOC_STEP_MS * `HOC_CLK_KHZ)
`endif

//--- hw/hoc_pkg.sv
// Types shared by the stage and its environment
// Assumes nothing beyond a SystemVerilog compiler
package hoc_pkg;
  typedef enum logic [1:0] {
    HOC_NORMAL,
    HOC_START,
    HOC_TRIP,
    HOC_BLOCKED
  } hoc_status_t;
  typedef enum logic [1:0] {
    HOC_SRC_PHASE,
    HOC_SRC_RES1,
    HOC_SRC_RES2,
    HOC_SRC_RSVD
  } hoc_src_t;
endpackage

//--- hw/hoc_stage.sv
// Harmonic overcurrent stage with a classic Wishbone register slave
// Assumes phase magnitudes arrive from another clock domain, residuals and block from logic
`timescale 1ns/1ps
`default_nettype none
`include "hoc_map.svh"

module hoc_stage #(
  parameter int MagW = 16,
  parameter int StepCyc = `HOC_STEP_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic [MagW*3-1:0] phaseFund,
  input wire logic [MagW*3-1:0] phaseHarm,
  input wire logic [MagW-1:0] residualOneFund,
  input wire logic [MagW-1:0] residualOneHarm,
  input wire logic [MagW-1:0] residualTwoFund,
  input wire logic [MagW-1:0] residualTwoHarm,
  output logic [4:0] harmonicOrder,
  input wire logic cycleTick,
  input wire logic blockIn,
  output logic startOut,
  output logic tripOut,
  output logic blockedOut
);
  // Magnitudes in units of 0.01 x In; phase inputs pulled through two flops, residuals used directly
  logic [MagW*3-1:0] fundS1Q, fundS2Q, harmS1Q, harmS2Q;
  logic [31:0] ctrlQ;
  logic [15:0] pickPuQ, pickRelQ, delayQ, groupQ;
  logic [31:0] ctrlD;
  logic ackQ, blockQ, pickQ, startQ, tripQ, blockedQ;
  logic [15:0] remainQ, expectQ, ratioQ;
  logic [31:0] rdDatQ;
  logic [$clog2(StepCyc+1)-1:0] stepQ;
  hoc_pkg::hoc_status_t statusQ;

  wire hoc_pkg::hoc_src_t src =
    hoc_pkg::hoc_src_t'(ctrlQ[`HOC_CTL_SRC_LO +: 2]);
  wire relMode = ctrlQ[`HOC_CTL_MODE];
  wire idmt = ctrlQ[`HOC_CTL_IDMT];
  wire forceEn = ctrlQ[`HOC_CTL_FEN];
  wire [1:0] forceSel = ctrlQ[`HOC_CTL_FORCE_LO +: 2];
  wire [4:0] harmSet = ctrlQ[`HOC_CTL_HARM_LO +: 5];

  // Residual sources only feed lane 0; other lanes are held at zero
  function automatic logic [MagW-1:0] lane(input logic [MagW*3-1:0] v,
      input logic [MagW-1:0] r1, input logic [MagW-1:0] r2,
      input hoc_pkg::hoc_src_t s, input int i);
    logic [MagW-1:0] l;
    l = v[i*MagW +: MagW];
    case (s)
      hoc_pkg::HOC_SRC_RES1: lane = (i == 0) ? r1 : '0;
      hoc_pkg::HOC_SRC_RES2: lane = (i == 0) ? r2 : '0;
      default: lane = l;
    endcase
  endfunction

  // Quantity per lane: harmonic in 0.01 In, or in 0.01 % of fundamental
  logic [31:0] meas [3];
  logic [2:0] over, above;
  wire [15:0] setting = relMode ? pickRelQ : pickPuQ;
  wire [31:0] relLevel = 32'(setting) * 32'(`HOC_RESET_RATIO);
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gLane
      wire [MagW-1:0] h = lane(harmS2Q, residualOneHarm,
                               residualTwoHarm, src, g);
      wire [MagW-1:0] f = lane(fundS2Q, residualOneFund,
                               residualTwoFund, src, g);
      wire [31:0] rel = (f == '0) ? 32'h0000_0000 :
        32'((64'(h) * 64'h0000_2710) / 64'(f));
      assign meas[g] = relMode ? rel : 32'(h);
      assign over[g] = meas[g] > 32'(setting);
      assign above[g] = 32'(meas[g]) * 32'h0000_0064 >= relLevel;
    end
  endgenerate
  wire [31:0] mMax = (meas[0] > meas[1]) ?
    ((meas[0] > meas[2]) ? meas[0] : meas[2]) :
    ((meas[1] > meas[2]) ? meas[1] : meas[2]);
  wire pickD = pickQ ? |above : |over;
  wire [31:0] ratioW = (setting == 16'h0000) ? 32'h0000_0000 :
    (mMax * 32'h0000_0064) / 32'(setting);

  // Inverse curve: delay scaled by setting over measured, floored at one
  wire [31:0] invW = (mMax == 0) ? 32'(delayQ) :
    (32'(delayQ) * 32'(setting)) / mMax;
  wire [15:0] expD = idmt ? ((invW == 0) ? 16'h0001 :
    (invW > 32'h0000_FFFF ? 16'hFFFF : invW[15:0])) : delayQ;

  // Register bus
  wire access = wb_cyc_i & wb_stb_i & ~ackQ;
  wire wrCtrl = access & wb_we_i & (wb_adr_i[7:0] == `HOC_ADR_CTRL);
  function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
  endfunction
  wire [31:0] wrVal = merge(ctrlQ, wb_dat_i, wb_sel_i);
  wire [4:0] wrHarm = wrVal[`HOC_CTL_HARM_LO +: 5];
  // Out-of-range harmonic orders keep the previous choice
  wire harmOk = wrHarm >= `HOC_HARM_MIN && wrHarm <= `HOC_HARM_MAX;
  always_comb begin
    ctrlD = ctrlQ;
    if (wrCtrl) begin
      ctrlD = wrVal;
      if (!harmOk)
        ctrlD[`HOC_CTL_HARM_LO +: 5] = harmSet;
    end
  end
  wire [31:0] rdMux =
    (wb_adr_i[7:0] == `HOC_ADR_CTRL) ? ctrlQ :
    (wb_adr_i[7:0] == `HOC_ADR_PICKPU) ? 32'(pickPuQ) :
    (wb_adr_i[7:0] == `HOC_ADR_PICKREL) ? 32'(pickRelQ) :
    (wb_adr_i[7:0] == `HOC_ADR_DELAY) ? 32'(delayQ) :
    (wb_adr_i[7:0] == `HOC_ADR_STATUS) ? 32'(statusQ) :
    (wb_adr_i[7:0] == `HOC_ADR_RATIO) ? 32'(ratioQ) :
    (wb_adr_i[7:0] == `HOC_ADR_EXPECT) ? 32'(expectQ) :
    (wb_adr_i[7:0] == `HOC_ADR_REMAIN) ? 32'(remainQ) :
    (wb_adr_i[7:0] == `HOC_ADR_GROUP) ? 32'(groupQ) : 32'h0000_0000;

  always_ff @(posedge core_clk) begin
    fundS1Q <= phaseFund;
    harmS1Q <= phaseHarm;
    fundS2Q <= fundS1Q;
    harmS2Q <= harmS1Q;
  end

  // All settings are per instance; writes apply at once
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrlQ <= `HOC_CTRL_RST;
      pickPuQ <= `HOC_PICKPU_RST;
      pickRelQ <= `HOC_PICKREL_RST;
      delayQ <= `HOC_DELAY_RST;
      groupQ <= 16'h0000;
      ackQ <= 1'b0;
      rdDatQ <= 32'h0000_0000;
    end else begin
      ackQ <= access;
      rdDatQ <= rdMux;
      ctrlQ <= ctrlD;
      if (access & wb_we_i) begin
        if (wb_adr_i[7:0] == `HOC_ADR_PICKPU)
          pickPuQ <= wb_dat_i[15:0];
        if (wb_adr_i[7:0] == `HOC_ADR_PICKREL)
          pickRelQ <= wb_dat_i[15:0];
        if (wb_adr_i[7:0] == `HOC_ADR_DELAY)
          delayQ <= wb_dat_i[15:0];
        if (wb_adr_i[7:0] == `HOC_ADR_GROUP)
          groupQ <= wb_dat_i[15:0];
      end
    end
  end

  // Program cycle evaluation; block is latched on the same tick that pick-up is judged
  wire stepEnd = stepQ == '0;
  wire timing = startQ & ~tripQ;
  wire clearNow = cycleTick & (~pickD | blockIn);
  // A step end on a tick still counts, or the delay would stretch
  wire stepDue = timing & stepEnd & ~clearNow;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      blockQ <= 1'b0;
      pickQ <= 1'b0;
      startQ <= 1'b0;
      tripQ <= 1'b0;
      blockedQ <= 1'b0;
      remainQ <= 16'h0000;
      expectQ <= 16'h0000;
      ratioQ <= 16'h0000;
      stepQ <= '0;
    end else begin
      stepQ <= (stepEnd || !timing) ? ($bits(stepQ))'(StepCyc - 1)
                                    : stepQ - 1'b1;
      if (cycleTick) begin
        blockQ <= blockIn;
        pickQ <= pickD;
        ratioQ <= (ratioW > 32'h0000_FFFF) ? 16'hFFFF : ratioW[15:0];
        expectQ <= expD;
        blockedQ <= pickD & blockIn;
      end
      if (clearNow) begin
        startQ <= 1'b0;
        tripQ <= 1'b0;
        remainQ <= 16'h0000;
      end else if (cycleTick && !startQ) begin
        startQ <= 1'b1;
        remainQ <= expD;
      end else if (stepDue) begin
        if (remainQ <= 16'h0001) begin
          remainQ <= 16'h0000;
          tripQ <= 1'b1;
        end else
          remainQ <= remainQ - 16'h0001;
      end
    end
  end

  // Forcing only honoured while the force enable bit in the control register is set
  wire forcing = forceEn && forceSel != 2'b00;
  wire hoc_pkg::hoc_status_t compSt = blockedQ ? hoc_pkg::HOC_BLOCKED :
    tripQ ? hoc_pkg::HOC_TRIP :
    startQ ? hoc_pkg::HOC_START : hoc_pkg::HOC_NORMAL;
  wire hoc_pkg::hoc_status_t outSt = forcing ?
    hoc_pkg::hoc_status_t'(forceSel) : compSt;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      statusQ <= hoc_pkg::HOC_NORMAL;
      startOut <= 1'b0;
      tripOut <= 1'b0;
      blockedOut <= 1'b0;
      harmonicOrder <= `HOC_HARM_MIN;
    end else begin
      statusQ <= outSt;
      startOut <= outSt == hoc_pkg::HOC_START ||
                  outSt == hoc_pkg::HOC_TRIP;
      tripOut <= outSt == hoc_pkg::HOC_TRIP;
      blockedOut <= outSt == hoc_pkg::HOC_BLOCKED;
      harmonicOrder <= harmSet;
    end
  end
  assign wb_ack_o = ackQ;
  assign wb_dat_o = rdDatQ;

  a_block_start: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    cycleTick && blockIn |=> !startQ)
    else $error("start set while blocked");
  a_pick_start: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    cycleTick && pickD && !blockIn |=> startQ)
    else $error("pick-up without start");
  a_drop_clear: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    cycleTick && !pickD |=> !startQ && !tripQ)
    else $error("start held after release");
  a_trip_zero: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $rose(tripQ) |-> remainQ == 16'h0000)
    else $error("trip with time left");
  a_force_out: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    forcing |=> 2'(statusQ) == $past(forceSel))
    else $error("force not applied");
  a_no_force: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !forceEn |=> statusQ == $past(compSt))
    else $error("force without enable");
  a_harm_range: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    harmonicOrder >= `HOC_HARM_MIN && harmonicOrder <= `HOC_HARM_MAX)
    else $error("harmonic order out of range");
  a_block_samp: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    cycleTick |=> blockQ == $past(blockIn))
    else $error("block not sampled");
  a_hold_level: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    cycleTick && pickQ && |above |=> pickQ)
    else $error("released above reset level");
  a_bus_ack: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  a_ack_answer: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    access |=> wb_ack_o)
    else $error("request not answered");
  a_ack_cause: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_pu_write: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    access && wb_we_i && wb_adr_i[7:0] == `HOC_ADR_PICKPU |=>
    pickPuQ == $past(wb_dat_i[15:0]))
    else $error("pick-up setting write lost");
  a_pu_only: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $changed(pickPuQ) |-> $past(access && wb_we_i))
    else $error("pick-up setting changed alone");
  a_delay_write: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    access && wb_we_i && wb_adr_i[7:0] == `HOC_ADR_DELAY |=>
    delayQ == $past(wb_dat_i[15:0]))
    else $error("delay write lost");
  a_group_write: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    access && wb_we_i && wb_adr_i[7:0] == `HOC_ADR_GROUP |=>
    groupQ == $past(wb_dat_i[15:0]))
    else $error("group write lost");
  a_harm_keep: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wrCtrl && !harmOk |=> $stable(harmSet))
    else $error("illegal order taken");
  a_harm_take: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wrCtrl && harmOk |=> harmSet == $past(wrHarm))
    else $error("legal order not taken");
  a_trip_start: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    tripQ |-> startQ)
    else $error("trip without start");
  a_blocked_idle: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    blockedQ |-> !startQ)
    else $error("start while blocked");
  a_blocked_set: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    cycleTick && pickD && blockIn |=> blockedQ)
    else $error("blocked not shown");
  a_release_low: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    cycleTick && pickQ && !(|above) |=> !pickQ)
    else $error("held below reset level");
  a_pick_over: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    cycleTick && !pickQ && |over |=> pickQ)
    else $error("no pick-up above setting");
  a_no_pick: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    cycleTick && !pickQ && !(|over) |=> !pickQ)
    else $error("pick-up below setting");
  a_remain_step: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    stepDue && remainQ > 16'h0001 |=>
    remainQ == $past(remainQ) - 16'h0001)
    else $error("remaining time not counted");
  a_remain_hold: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    timing && !stepEnd && !clearNow |=> $stable(remainQ))
    else $error("remaining time moved between steps");
  a_trip_due: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    stepDue && remainQ <= 16'h0001 |=> tripQ)
    else $error("no trip at zero");
  a_start_load: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    cycleTick && pickD && !blockIn && !startQ |=> remainQ == $past(expD))
    else $error("timing not loaded at start");
  a_dt_expect: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    cycleTick && !idmt |=> expectQ == $past(delayQ))
    else $error("definite time not shown");
  a_force_block: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    forcing && forceSel == 2'b11 |=> blockedOut && !startOut)
    else $error("forced block not shown");
endmodule
`default_nettype wire

//--- testbench/hoc_front_model.sv
// Measurement front end and blocking matrix seen by the stage
// Assumes the bench sets the level, the carrying lane and the block
`timescale 1ns/1ps
`default_nettype none
module hoc_front_model #(
  parameter logic [4:0] HarmOrder = 5'h05
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [4:0] harmonicOrder,
  input wire logic [15:0] harmLevel,
  input wire logic [1:0] laneSel,
  input wire logic blockReq,
  output logic [47:0] phaseFund,
  output logic [47:0] phaseHarm,
  output logic [15:0] resOneFund,
  output logic [15:0] resOneHarm,
  output logic [15:0] resTwoFund,
  output logic [15:0] resTwoHarm,
  output logic cycleTick,
  output var logic blockIn
);
  logic [2:0] tickCnt_q;
  // Only one order carries content, so a wrong order reads as zero
  wire [15:0] harmNow = (harmonicOrder == HarmOrder) ? harmLevel : 16'h0000;
  wire [15:0] z = 16'h0000;
  assign phaseFund = {3{16'h0064}};
  assign phaseHarm = {(laneSel == 2'h2) ? harmNow : z,
    (laneSel == 2'h1) ? harmNow : z, (laneSel == 2'h0) ? harmNow : z};
  assign resOneFund = 16'h0064;
  assign resOneHarm = (laneSel == 2'h3) ? harmNow : z;
  assign resTwoFund = 16'h0064;
  assign resTwoHarm = z;
  assign cycleTick = (tickCnt_q == 3'h7);
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tickCnt_q <= 3'h0;
      blockIn <= 1'b0;
    end else begin
      tickCnt_q <= tickCnt_q + 3'h1;
      // Block moves only at a cycle boundary, well ahead of expiry
      if (cycleTick) blockIn <= blockReq;
    end
  end
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// Register and status sequences for the harmonic stage
// Assumes a short time step of four cycles and the front end model
`timescale 1ns/1ps
`default_nettype none
`include "hoc_map.svh"
module tb_top;
  logic core_clk = 1'b0, rst_n = 1'b0;
  logic [31:0] wbAdr = 32'h0000_0000, wbDatW = 32'h0000_0000, wbDatR;
  logic [3:0] wbSel = 4'hF;
  logic wbWe = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, wbAck;
  logic [47:0] phF, phH;
  logic [15:0] r1F, r1H, r2F, r2H, level = 16'h0000;
  logic [4:0] hOrd;
  logic [1:0] lane = 2'h0;
  logic tick, blk, startO, tripO, blockedO, blockReq = 1'b0;
  int errTotal = 0, nCompared = 0, w;
  always #10 core_clk = ~core_clk;
  hoc_stage #(.StepCyc(4)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
    .wb_adr_i(wbAdr), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
    .wb_sel_i(wbSel), .wb_we_i(wbWe), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_ack_o(wbAck), .phaseFund(phF), .phaseHarm(phH),
    .residualOneFund(r1F), .residualOneHarm(r1H), .residualTwoFund(r2F),
    .residualTwoHarm(r2H), .harmonicOrder(hOrd), .cycleTick(tick),
    .blockIn(blk), .startOut(startO), .tripOut(tripO),
    .blockedOut(blockedO));
  hoc_front_model i_fe (.core_clk(core_clk), .rst_n(rst_n),
    .harmonicOrder(hOrd), .harmLevel(level), .laneSel(lane),
    .blockReq(blockReq), .phaseFund(phF), .phaseHarm(phH),
    .resOneFund(r1F), .resOneHarm(r1H), .resTwoFund(r2F),
    .resTwoHarm(r2H), .cycleTick(tick), .blockIn(blk));
  task automatic printVerdict();
    $display("compared %0d mismatched %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    nCompared++;
    if (g !== e) begin
      errTotal++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request held until ack is seen at a rising edge
  task automatic bus(input logic [7:0] a, input logic we,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= {24'h00_0000, a};
    wbDatW <= d;
    do @(posedge core_clk); while (wbAck !== 1'b1);
    q = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic rdChk(input string nm, input logic [7:0] a,
    input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0000_0000, q);
    chk(nm, e, q);
  endtask
  function automatic logic [31:0] cw(input logic [4:0] o, input logic m,
    input logic [1:0] s, input logic [1:0] f, input logic en);
    return {21'h00_0000, en, f, s, m, o};
  endfunction
  // Several program cycles, enough for the two-flop input path
  task automatic run(input logic [31:0] c, input logic [15:0] lv,
    input logic [1:0] ln, input logic b);
    level <= lv;
    lane <= ln;
    blockReq <= b;
    wr(`HOC_ADR_CTRL, c);
    repeat (40) @(posedge core_clk);
  endtask
  task automatic outs(input logic [2:0] e);
    chk("start trip blocked", {29'h0, e}, {29'h0, startO, tripO, blockedO});
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    errTotal++;
    printVerdict();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    rdChk("ctrl", `HOC_ADR_CTRL, 32'h0000_0002);
    chk("order", 32'h0000_0002, {27'h0, hOrd});
    rdChk("pu set", `HOC_ADR_PICKPU, 32'h0000_0014);
    rdChk("rel set", `HOC_ADR_PICKREL, 32'h0000_07D0);
    rdChk("unmapped", 8'h40, 32'h0000_0000);
    run(cw(5'h02, 0, 0, 0, 0), 16'h001E, 2'h0, 0);
    outs(3'b000);
    wr(`HOC_ADR_DELAY, 32'h0000_0064);
    run(cw(5'h05, 0, 0, 0, 0), 16'h001E, 2'h0, 0);
    outs(3'b100);
    rdChk("status", `HOC_ADR_STATUS, {30'h0, hoc_pkg::HOC_START});
    rdChk("ratio", `HOC_ADR_RATIO, 32'h0000_0096);
    wr(`HOC_ADR_CTRL, cw(5'h14, 0, 0, 0, 0));
    repeat (2) @(posedge core_clk);
    chk("order kept", 32'h0000_0005, {27'h0, hOrd});
    rdChk("ctrl kept", `HOC_ADR_CTRL, 32'h0000_0005);
    run(cw(5'h05, 0, 0, 0, 0), 16'h001E, 2'h2, 0);
    outs(3'b100);
    run(cw(5'h05, 0, 0, 0, 0), 16'h0014, 2'h1, 0);
    outs(3'b100);
    run(cw(5'h05, 0, 0, 0, 0), 16'h0013, 2'h1, 0);
    outs(3'b000);
    run(cw(5'h05, 0, 0, 0, 0), 16'h001E, 2'h0, 0);
    wr(`HOC_ADR_PICKPU, 32'h0000_0028);
    repeat (40) @(posedge core_clk);
    outs(3'b000);
    wr(`HOC_ADR_PICKPU, 32'h0000_0014);
    run(cw(5'h05, 0, 0, 0, 0), 16'h001E, 2'h0, 1);
    outs(3'b001);
    run(cw(5'h05, 0, 0, 0, 0), 16'h0000, 2'h0, 0);
    run(cw(5'h05, 0, 0, 0, 0), 16'h001E, 2'h0, 0);
    run(cw(5'h05, 0, 0, 0, 0), 16'h001E, 2'h0, 1);
    chk("start trip", 32'h0, {30'h0, startO, tripO});
    outs(3'b001);
    run(cw(5'h05, 0, 2'h2, 0, 0), 16'h001E, 2'h0, 0);
    outs(3'b000);
    run(cw(5'h05, 0, 2'h1, 0, 0), 16'h001E, 2'h3, 0);
    outs(3'b100);
    run(cw(5'h05, 1, 0, 0, 0), 16'h001E, 2'h0, 0);
    outs(3'b100);
    run(cw(5'h05, 1, 0, 0, 0), 16'h000F, 2'h0, 0);
    outs(3'b000);
    run(cw(5'h05, 0, 0, 2'h2, 0), 16'h0000, 2'h0, 0);
    outs(3'b000);
    run(cw(5'h05, 0, 0, 2'h2, 1), 16'h0000, 2'h0, 0);
    chk("forced trip", 32'h1, {31'h0, tripO});
    run(cw(5'h05, 0, 0, 2'h1, 1), 16'h0000, 2'h0, 0);
    outs(3'b100);
    run(cw(5'h05, 0, 0, 2'h3, 1), 16'h0000, 2'h0, 0);
    outs(3'b001);
    run(cw(5'h05, 0, 0, 0, 1), 16'h0000, 2'h0, 0);
    outs(3'b000);
    run(cw(5'h05, 0, 0, 0, 0) | 32'h0000_0800, 16'h0028, 2'h0, 0);
    rdChk("idmt time", `HOC_ADR_EXPECT, 32'h0000_0032);
    run(cw(5'h05, 0, 0, 0, 0), 16'h0000, 2'h0, 0);
    wr(`HOC_ADR_DELAY, 32'h0000_0002);
    run(cw(5'h05, 0, 0, 0, 0), 16'h001E, 2'h0, 0);
    for (w = 0; w < 200 && tripO !== 1'b1; w++) @(posedge core_clk);
    outs(3'b110);
    rdChk("remain", `HOC_ADR_REMAIN, 32'h0000_0000);
    rdChk("expect", `HOC_ADR_EXPECT, 32'h0000_0002);
    rdChk("status", `HOC_ADR_STATUS, {30'h0, hoc_pkg::HOC_TRIP});
    wr(`HOC_ADR_GROUP, 32'h0000_0003);
    rdChk("group", `HOC_ADR_GROUP, 32'h0000_0003);
    printVerdict();
  end
endmodule
`default_nettype wire
